// [current_sense_ctrl.sv]
// Current sense digital control: per-channel offset compensation,
// comparator feedback to the microcore and channel four converter
// regulation with negative current detection.
// Assumes comparator outputs are asynchronous analog levels and the
// microcore commands come from logic on sys_clk.
`timescale 1ns/1ps

// How it works
// - Each of four channels has offset compensation
// - Start loads threshold DAC with bias code
// - Feedback reads low after compensation completes
// - New run starts from previous value
// - Stop aborts and keeps reached value
// - Stored value limited to -31..+31
// - Each step takes at most 2 us
// - Whole run finishes within 62 us
// - Hard-wired two-point logic drives converter gate
// - Third comparator flags negative current
// - Channel four: plain channel or converter feedback
// - Feedback high when amplified sense exceeds threshold
module current_sense_ctrl #(
  parameter int N_CH = 4
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_b,
  input  wire logic                          ce,
  input  wire cs_pkg::cal_cmd_s [N_CH-1:0]   cal_cmd,
  input  wire logic [N_CH-1:0]               cmp_raw,
  input  wire logic                          ch4_low_cmp_raw,
  input  wire logic                          neg_cmp_raw,
  input  wire logic                          dcdc_mode,
  input  wire logic [N_CH-1:0][cs_pkg::DAC_W-1:0] dac_code_in,
  output logic [N_CH-1:0][cs_pkg::DAC_W-1:0] dac_code_out,
  output cs_pkg::offs_t [N_CH-1:0]           offset_out,
  output cs_pkg::cal_stat_s [N_CH-1:0]       cal_stat,
  output logic [N_CH-1:0]                    cmp_fbk,
  output logic                               ch4_high_compare_feedback,
  output logic                               ch4_low_compare_feedback,
  output logic                               neg_current_fbk,
  output logic                               converter_lowside_gate_out
);
  import cs_pkg::*;

  localparam int SYN_W = N_CH + 2;
  localparam int LOW_IX = N_CH;
  localparam int NEG_IX = N_CH + 1;
  localparam int CH4 = N_CH - 1;

  logic [SYN_W-1:0] sync1_q, sync2_q;
  logic [N_CH-1:0]  fbk_q, fbk_d;
  logic [N_CH-1:0][DAC_W-1:0] dac_q, dac_d;
  logic             low_q, low_d;
  logic             neg_q, neg_d;
  logic             gate_q, gate_d;

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  // Two flops per comparator level before any logic reads it
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (ce) begin
      sync1_q <= {neg_cmp_raw, ch4_low_cmp_raw, cmp_raw};
      sync2_q <= sync1_q;
    end
  end

  // ------------------------------------------------------------------
  // Per-channel compensation and feedback
  // ------------------------------------------------------------------
  for (genvar i = 0; i < N_CH; i++) begin : g_ch
    offset_cal_engine u_cal (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .ce      (ce),
      .cmd     (cal_cmd[i]),
      .cmp     (sync2_q[i]),
      .offset  (offset_out[i]),
      .stat    (cal_stat[i])
    );

    // Feedback masked during and after a completed run; DAC forced to bias code only during a run
    always_comb begin
      fbk_d[i] = sync2_q[i];
      if (cal_stat[i].busy || cal_stat[i].done) begin
        fbk_d[i] = 1'b0;
      end
      dac_d[i] = dac_code_in[i];
      if (cal_stat[i].busy) begin
        dac_d[i] = DAC_COMP_CODE;
      end
    end
  end

  // ------------------------------------------------------------------
  // Channel four converter regulation
  // ------------------------------------------------------------------
  // Off above high threshold wins, on below low threshold, else hold
  always_comb begin
    low_d  = sync2_q[LOW_IX];
    neg_d  = sync2_q[NEG_IX];
    gate_d = gate_q;
    if (!dcdc_mode) begin
      gate_d = 1'b0;
    end else if (cal_stat[CH4].busy) begin
      gate_d = 1'b0;
    end else if (sync2_q[CH4]) begin
      gate_d = 1'b0;
    end else if (!sync2_q[LOW_IX]) begin
      gate_d = 1'b1;
    end
  end

  // Output registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      fbk_q  <= '0;
      dac_q  <= '0;
      low_q  <= 1'b0;
      neg_q  <= 1'b0;
      gate_q <= 1'b0;
    end else if (ce) begin
      fbk_q  <= fbk_d;
      dac_q  <= dac_d;
      low_q  <= low_d;
      neg_q  <= neg_d;
      gate_q <= gate_d;
    end
  end

  // High comparator feedback, masked low while channel four compensation is busy or done
  assign cmp_fbk                    = fbk_q;
  assign dac_code_out               = dac_q;
  assign ch4_high_compare_feedback  = fbk_q[CH4];
  assign ch4_low_compare_feedback   = low_q;
  assign neg_current_fbk            = neg_q;
  assign converter_lowside_gate_out = gate_q;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_gate_off;
    @(posedge sys_clk) disable iff (!rst_b)
      ce && sync2_q[CH4] |=> !converter_lowside_gate_out;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("gate not off above high threshold");

  property p_gate_on;
    @(posedge sys_clk) disable iff (!rst_b)
      ce && dcdc_mode && !cal_stat[CH4].busy && !sync2_q[CH4] &&
      !sync2_q[LOW_IX] |=> converter_lowside_gate_out;
  endproperty
  a_gate_on: assert property (p_gate_on)
    else $error("gate not on below low threshold");

  property p_gate_hold;
    @(posedge sys_clk) disable iff (!rst_b)
      ce && dcdc_mode && !cal_stat[CH4].busy && !sync2_q[CH4] &&
      sync2_q[LOW_IX] |=> $stable(converter_lowside_gate_out);
  endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("gate changed between thresholds");

  property p_mode_off;
    @(posedge sys_clk) disable iff (!rst_b)
      ce && !dcdc_mode |=> !converter_lowside_gate_out;
  endproperty
  a_mode_off: assert property (p_mode_off)
    else $error("gate driven outside converter mode");

  property p_fbk_low;
    @(posedge sys_clk) disable iff (!rst_b)
      ce && cal_stat[0].done |=> !cmp_fbk[0];
  endproperty
  a_fbk_low: assert property (p_fbk_low)
    else $error("feedback high after compensation");

  property p_fbk_follow;
    @(posedge sys_clk) disable iff (!rst_b)
      ce && !cal_stat[0].busy && !cal_stat[0].done
      |=> cmp_fbk[0] == $past(sync2_q[0]);
  endproperty
  a_fbk_follow: assert property (p_fbk_follow)
    else $error("feedback does not follow comparator");

  property p_dac_bias;
    @(posedge sys_clk) disable iff (!rst_b)
      ce && cal_stat[0].busy |=> dac_code_out[0] == DAC_COMP_CODE;
  endproperty
  a_dac_bias: assert property (p_dac_bias)
    else $error("DAC not at bias code during run");

  property p_neg;
    @(posedge sys_clk) disable iff (!rst_b)
      ce |=> neg_current_fbk == $past(sync2_q[NEG_IX]);
  endproperty
  a_neg: assert property (p_neg)
    else $error("negative current flag wrong");

endmodule

// [cs_pkg.sv]
// Shared constants and types for the current sense offset compensation
// and the channel four two-point converter regulation.
// Assumes a single 20 MHz core clock with a synchronous active-low reset.
package cs_pkg;

  // ------------------------------------------------------------------
  // Threshold DAC and compensation value
  // ------------------------------------------------------------------
  localparam int DAC_W  = 8;
  localparam logic [DAC_W-1:0] DAC_COMP_CODE = 8'h1A; // Bias level code
  localparam int OFFS_W = 6;
  typedef logic signed [OFFS_W-1:0] offs_t;
  localparam offs_t OFFS_MAX   = 6'sh1F;  // +31
  localparam offs_t OFFS_MIN   = -6'sh1F; // -31
  localparam offs_t OFFS_RESET = 6'sh00;
  localparam offs_t OFFS_STEP  = 6'sh01;  // One compensation step

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam real CLK_MHZ     = 20.0;
  localparam real STEP_TIME_US = 2.0;   // Longest step time
  localparam real RUN_TIME_US  = 62.0;  // Longest whole run
  localparam int  STEP_CYC  = $rtoi(STEP_TIME_US * CLK_MHZ);
  localparam int  RUN_CYC   = $rtoi(RUN_TIME_US * CLK_MHZ);
  localparam int  MAX_STEPS = RUN_CYC / STEP_CYC;
  localparam int  TMR_W = $clog2(STEP_CYC);
  localparam int  STP_W = $clog2(MAX_STEPS);
  localparam int  RUN_W = $clog2(RUN_CYC + 1);
  localparam logic [TMR_W-1:0] STEP_LOAD = TMR_W'(STEP_CYC - 1);
  localparam logic [TMR_W-1:0] TMR_ZERO  = '0;
  localparam logic [STP_W-1:0] STP_LAST  = STP_W'(MAX_STEPS - 1);
  localparam logic [STP_W-1:0] STP_ZERO  = '0;
  localparam logic [RUN_W-1:0] RUN_LIMIT = RUN_W'(RUN_CYC);

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} cal_state_e;

  typedef struct packed {
    logic start;  // Start-compensation instruction, one-cycle pulse
    logic stop;   // Stop-compensation instruction, one-cycle pulse
  } cal_cmd_s;

  typedef struct packed {
    logic busy;   // Run in progress, DAC forced to bias code
    logic done;   // Run finished, held until stop or restart
  } cal_stat_s;

endpackage

// [offset_cal_engine.sv]
// Offset compensation sequencer for one current sense channel.
// Assumes the comparator input is already synchronised to sys_clk.
`timescale 1ns/1ps
module offset_cal_engine (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  input  wire cs_pkg::cal_cmd_s cmd,
  input  wire logic             cmp,
  output cs_pkg::offs_t         offset,
  output cs_pkg::cal_stat_s     stat
);
  import cs_pkg::*;

  cal_state_e       st_q,  st_d;
  offs_t            off_q, off_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [STP_W-1:0] stp_q, stp_d;
  logic             dir_q, dir_d;
  logic             first_q, first_d;
  logic [RUN_W-1:0] run_q, run_d;

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  // Next state: one step per interval toward the comparator crossing
  always_comb begin
    st_d    = st_q;
    off_d   = off_q;
    tmr_d   = tmr_q;
    stp_d   = stp_q;
    dir_d   = dir_q;
    first_d = first_q;
    case (st_q)
      ST_IDLE, ST_DONE: begin
        if (cmd.start) begin
          st_d    = ST_RUN;       // Value kept from previous run
          tmr_d   = STEP_LOAD;
          stp_d   = STP_ZERO;
          first_d = 1'b1;
        end else if (cmd.stop) begin
          st_d = ST_IDLE;
        end
      end
      ST_RUN: begin
        if (cmd.stop) begin
          st_d = ST_IDLE;         // Abort, value held
        end else if (tmr_q != TMR_ZERO) begin
          tmr_d = tmr_q - 1'b1;
        end else begin
          tmr_d   = STEP_LOAD;
          dir_d   = cmp;
          first_d = 1'b0;
          stp_d   = stp_q + 1'b1;
          if (!first_q && (cmp != dir_q)) begin
            st_d = ST_DONE;       // Crossing reached
          end else if (cmp) begin
            if (off_q == OFFS_MIN) st_d = ST_DONE;
            else off_d = off_q - OFFS_STEP;
          end else begin
            if (off_q == OFFS_MAX) st_d = ST_DONE;
            else off_d = off_q + OFFS_STEP;
          end
          if (stp_q == STP_LAST) st_d = ST_DONE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // Registers, frozen while the clock enable is low
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_q    <= ST_IDLE;
      off_q   <= OFFS_RESET;
      tmr_q   <= TMR_ZERO;
      stp_q   <= STP_ZERO;
      dir_q   <= 1'b0;
      first_q <= 1'b1;
    end else if (ce) begin
      st_q    <= st_d;
      off_q   <= off_d;
      tmr_q   <= tmr_d;
      stp_q   <= stp_d;
      dir_q   <= dir_d;
      first_q <= first_d;
    end
  end

  // Outputs straight from state flops
  assign offset    = off_q;
  assign stat      = '{busy: (st_q == ST_RUN), done: (st_q == ST_DONE)};

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  // Cycles spent in the current run
  always_comb begin
    run_d = run_q;
    if (st_q != ST_RUN) run_d = '0;
    else if (run_q != RUN_LIMIT) run_d = run_q + 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) run_q <= '0;
    else if (ce) run_q <= run_d;
  end

  property p_start_runs;
    @(posedge sys_clk) disable iff (!rst_b)
      ce && cmd.start && (st_q != ST_RUN) |=> stat.busy;
  endproperty
  a_start_runs: assert property (p_start_runs)
    else $error("start did not begin a run");

  property p_start_keeps;
    @(posedge sys_clk) disable iff (!rst_b)
      ce && cmd.start && (st_q != ST_RUN) |=> offset == $past(offset);
  endproperty
  a_start_keeps: assert property (p_start_keeps)
    else $error("start disturbed the stored offset");

  property p_abort_holds;
    @(posedge sys_clk) disable iff (!rst_b)
      ce && stat.busy && cmd.stop |=> !stat.busy && $stable(offset);
  endproperty
  a_abort_holds: assert property (p_abort_holds)
    else $error("stop did not abort with offset held");

  property p_range;
    @(posedge sys_clk) disable iff (!rst_b)
      offset >= OFFS_MIN && offset <= OFFS_MAX;
  endproperty
  a_range: assert property (p_range)
    else $error("offset outside range");

  property p_step_spacing;
    @(posedge sys_clk) disable iff (!rst_b)
      stat.busy && (tmr_q != TMR_ZERO) |=> $stable(offset);
  endproperty
  a_step_spacing: assert property (p_step_spacing)
    else $error("offset moved between step ticks");

  property p_run_bound;
    @(posedge sys_clk) disable iff (!rst_b)
      stat.busy |-> run_q < RUN_LIMIT;
  endproperty
  a_run_bound: assert property (p_run_bound)
    else $error("run exceeded its time limit");

  property p_step_down;
    @(posedge sys_clk) disable iff (!rst_b)
      ce && stat.busy && !cmd.stop && (tmr_q == TMR_ZERO) && cmp &&
      (first_q || dir_q) && (offset != OFFS_MIN)
      |=> offset == $past(offset) - OFFS_STEP;
  endproperty
  a_step_down: assert property (p_step_down)
    else $error("high comparator did not lower offset by one");

  property p_step_up;
    @(posedge sys_clk) disable iff (!rst_b)
      ce && stat.busy && !cmd.stop && (tmr_q == TMR_ZERO) && !cmp &&
      (first_q || !dir_q) && (offset != OFFS_MAX)
      |=> offset == $past(offset) + OFFS_STEP;
  endproperty
  a_step_up: assert property (p_step_up)
    else $error("low comparator did not raise offset by one");

endmodule

// [ucore_model.sv]
// Behavioural model of the microcore that sends compensation instructions.
// Assumes the bench calls issue() at a falling edge of sys_clk.
`timescale 1ns/1ps
module ucore_model (
  input  wire logic                 sys_clk,
  output cs_pkg::cal_cmd_s [3:0]    cal_cmd,
  output logic [3:0][7:0]           dac_code_in
);
  import cs_pkg::*;

  // ------------------------------------------------------------------
  // Instruction pulses
  // ------------------------------------------------------------------
  // Idle commands and a distinct threshold code per channel
  initial begin
    cal_cmd = '0;
    for (int i = 0; i < 4; i++) begin
      dac_code_in[i] = 8'h40 + 8'(i);
    end
  end

  // One-cycle start or stop pulse, launched off the sampling edge
  task automatic issue(input int ch, input logic st, input logic sp);
    cal_cmd[ch] <= '{start: st, stop: sp};
    @(negedge sys_clk);
    cal_cmd[ch] <= '0;
  endtask
endmodule

// [testbench.sv]
// Self-checking bench for the current sense control block.
// Assumes ucore_model supplies instructions; the bench models comparators.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, a, b); end end

module testbench;
  import cs_pkg::*;

  logic                 sys_clk;
  logic                 rst_b;
  logic                 ce;
  cal_cmd_s [3:0]       cal_cmd;
  logic [3:0]           cmp_raw;
  logic [3:0]           loop_en;
  logic [3:0]           cmp_man;
  logic                 ch4_low_cmp_raw;
  logic                 neg_cmp_raw;
  logic                 dcdc_mode;
  logic [3:0][7:0]      dac_code_in;
  logic [3:0][7:0]      dac_code_out;
  offs_t [3:0]          offset_out;
  cal_stat_s [3:0]      cal_stat;
  logic [3:0]           cmp_fbk;
  logic                 ch4_hi_fb;
  logic                 ch4_lo_fb;
  logic                 neg_fb;
  logic                 gate;
  int                   tgt [4];
  int                   error_cnt;
  int                   checks_done;

  // ------------------------------------------------------------------
  // Clock, partner and design
  // ------------------------------------------------------------------
  // 20 MHz core clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  ucore_model u_core (.sys_clk(sys_clk), .cal_cmd(cal_cmd),
                      .dac_code_in(dac_code_in));

  current_sense_ctrl #(.N_CH(4)) dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .cal_cmd(cal_cmd),
    .cmp_raw(cmp_raw), .ch4_low_cmp_raw(ch4_low_cmp_raw),
    .neg_cmp_raw(neg_cmp_raw), .dcdc_mode(dcdc_mode),
    .dac_code_in(dac_code_in), .dac_code_out(dac_code_out),
    .offset_out(offset_out), .cal_stat(cal_stat), .cmp_fbk(cmp_fbk),
    .ch4_high_compare_feedback(ch4_hi_fb),
    .ch4_low_compare_feedback(ch4_lo_fb),
    .neg_current_fbk(neg_fb), .converter_lowside_gate_out(gate));

  // Amplifier model: comparator high while the offset exceeds the target
  always @(negedge sys_clk) begin
    for (int i = 0; i < 4; i++) begin
      cmp_raw[i] <= loop_en[i] ? (offset_out[i] > tgt[i]) : cmp_man[i];
    end
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Prints the verdict and ends the run
  task automatic final_report;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Full run against a zero-current amplifier whose offset crosses at t
  task automatic run_cal(input int ch, input int t, input int exp_v);
    int    cyc;
    int    last;
    offs_t prev;
    tgt[ch] = t;
    loop_en[ch] = 1'b1;
    wait_cyc(4);
    u_core.issue(ch, 1'b1, 1'b0);
    wait_cyc(1);
    `CHK(cal_stat[ch].busy, 1'b1)
    `CHK(dac_code_out[ch], DAC_COMP_CODE)
    `CHK(cmp_fbk[ch], 1'b0)
    prev = offset_out[ch];
    last = -1;
    cyc = 0;
    while (cal_stat[ch].done !== 1'b1 && cyc < 1300) begin
      @(negedge sys_clk);
      cyc++;
      if (offset_out[ch] !== prev) begin
        if (last >= 0) `CHK(cyc - last, STEP_CYC)
        last = cyc;
        prev = offset_out[ch];
      end
    end
    if (cyc >= 1300) begin
      error_cnt++;
      final_report();
    end
    `CHK(cyc <= RUN_CYC, 1'b1)
    `CHK(offset_out[ch], offs_t'(exp_v))
    wait_cyc(5);
    `CHK(cal_stat[ch], 2'b01)
    `CHK(cmp_fbk[ch], 1'b0)
    loop_en[ch] = 1'b0;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  // Reset state and idle comparator path
  task automatic t_idle;
    `CHK(offset_out, '0)
    `CHK(cal_stat, '0)
    `CHK(gate, 1'b0)
    cmp_man[0] = 1'b1;
    wait_cyc(4);
    `CHK(cmp_fbk[0], 1'b1)
    `CHK(dac_code_out[0], dac_code_in[0])
    cmp_man[0] = 1'b0;
    wait_cyc(4);
    `CHK(cmp_fbk[0], 1'b0)
  endtask

  // Second run resumes from the first result
  task automatic t_resume;
    run_cal(0, 3, 4);
    run_cal(0, 1, 1);
  endtask

  // Stop in mid-run keeps the value reached
  task automatic t_abort;
    offs_t v;
    tgt[1] = 20;
    loop_en[1] = 1'b1;
    wait_cyc(4);
    u_core.issue(1, 1'b1, 1'b0);
    wait_cyc(99);
    v = offset_out[1];
    u_core.issue(1, 1'b0, 1'b1);
    `CHK(cal_stat[1], 2'b00)
    `CHK(v, offs_t'(2))
    wait_cyc(100);
    `CHK(offset_out[1], v)
    loop_en[1] = 1'b0;
    cmp_man[1] = 1'b1;
    wait_cyc(4);
    `CHK(cmp_fbk[1], 1'b1)
    cmp_man[1] = 1'b0;
  endtask

  // Clock enable low freezes synchronisers, feedback and instructions
  task automatic t_freeze;
    wait_cyc(4);
    ce = 1'b0;
    cmp_man[1] = 1'b1;
    u_core.issue(1, 1'b1, 1'b0);
    wait_cyc(5);
    `CHK(cal_stat[1], 2'b00)
    `CHK(cmp_fbk[1], 1'b0)
    ce = 1'b1;
    wait_cyc(4);
    `CHK(cmp_fbk[1], 1'b1)
    cmp_man[1] = 1'b0;
    wait_cyc(4);
    `CHK(cmp_fbk[1], 1'b0)
  endtask

  // Saturation at both range limits
  task automatic t_limits;
    run_cal(2, 40, 31);
    run_cal(2, 40, 31);
    run_cal(2, -40, 0);
    run_cal(2, -40, -31);
    run_cal(2, -40, -31);
  endtask

  // Two-point regulation, negative current flag, calibration override
  task automatic t_gate;
    dcdc_mode = 1'b1;
    neg_cmp_raw = 1'b1;
    wait_cyc(5);
    `CHK(gate, 1'b1)
    `CHK(neg_fb, 1'b1)
    ch4_low_cmp_raw = 1'b1;
    wait_cyc(5);
    `CHK(gate, 1'b1)
    `CHK(ch4_lo_fb, 1'b1)
    cmp_man[3] = 1'b1;
    wait_cyc(5);
    `CHK(gate, 1'b0)
    `CHK(ch4_hi_fb, 1'b1)
    `CHK(cmp_fbk[3], 1'b1)
    cmp_man[3] = 1'b0;
    neg_cmp_raw = 1'b0;
    wait_cyc(5);
    `CHK(gate, 1'b0)
    `CHK(neg_fb, 1'b0)
    ch4_low_cmp_raw = 1'b0;
    wait_cyc(5);
    `CHK(gate, 1'b1)
    u_core.issue(3, 1'b1, 1'b0);
    wait_cyc(2);
    `CHK(gate, 1'b0)
    u_core.issue(3, 1'b0, 1'b1);
    wait_cyc(5);
    `CHK(gate, 1'b1)
    dcdc_mode = 1'b0;
    wait_cyc(3);
    `CHK(gate, 1'b0)
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    error_cnt = 0;
    checks_done = 0;
    rst_b = 1'b0;
    ce = 1'b1;
    loop_en = '0;
    cmp_man = '0;
    ch4_low_cmp_raw = 1'b0;
    neg_cmp_raw = 1'b0;
    dcdc_mode = 1'b0;
    for (int i = 0; i < 4; i++) begin
      tgt[i] = 0;
    end
    repeat (3) @(negedge sys_clk);
    rst_b = 1'b1;
    wait_cyc(3);
    t_idle();
    t_resume();
    t_abort();
    t_freeze();
    t_limits();
    t_gate();
    final_report();
  end
endmodule
